// ---- sscr_pkg.sv ----
// Package of constants for the synthesizer sweep configuration register bank.
// Contract
// - Bit 21 adds divide-by-two before comparison.
// - Bit 20 doubles reference, both edges active.
// - Five-bit reference counter, ratios one to 32.
// - Bits 14:3 hold first step timer.
// - Low three bits route word to register.
// - Integer-load delay makes integer, fraction apply together.
// - Bit 14 clear resets modulator per write.
// - Bits 11:10 waveform, bit 9 PSK, 8 FSK.
// - Lock after 24 or 40 good cycles.
// - Bit 6 sets phase detector polarity.
// - Power-down forces counters, three-state, clears lock.
// - Bit 4 three-states pump, bit 3 holds counters.
// - Test bit 31 syncs strobe to reference.
// - Mode 01110 disables modulator; 00000 normal.
// - Test bits 20:19 divider mode, 18:7 timer.
// - Deviation bits choose ramp clock and ramp enables.
// - Interrupt type; data pin edge captures sweep.
// - Deviation select, offset, signed deviation word.
// - Step select and twenty-bit step count.
// - Delay register fast lock, delay, clock, start.
package sscr_pkg;

  // ****************************************************************
  // Register byte addresses, chosen for the bus.
  // ****************************************************************
  localparam logic [7:0] ADDR_REF_DIV    = 8'h00; // Reference-divider register.
  localparam logic [7:0] ADDR_FUNCTION   = 8'h04; // Function register.
  localparam logic [7:0] ADDR_TEST       = 8'h08; // Test register.
  localparam logic [7:0] ADDR_DEV_A      = 8'h0C; // First deviation word.
  localparam logic [7:0] ADDR_DEV_B      = 8'h10; // Second deviation word.
  localparam logic [7:0] ADDR_STEP_A     = 8'h14; // First step word.
  localparam logic [7:0] ADDR_STEP_B     = 8'h18; // Second step word.
  localparam logic [7:0] ADDR_RAMP_DELAY = 8'h1C; // Ramp delay register.
  localparam logic [7:0] ADDR_STATUS     = 8'h20; // Derived status register.
  localparam logic [7:0] ADDR_SERIAL     = 8'h24; // Last serial word shifted in.

  // ****************************************************************
  // Control codes in bits 2:0 of each word.
  // ****************************************************************
  localparam logic [2:0] CTL_REF_DIV  = 3'h2; // Reference divider.
  localparam logic [2:0] CTL_FUNCTION = 3'h3; // Function.
  localparam logic [2:0] CTL_TEST     = 3'h4; // Test.
  localparam logic [2:0] CTL_DEV      = 3'h5; // Deviation.
  localparam logic [2:0] CTL_STEP     = 3'h6; // Step.
  localparam logic [2:0] CTL_DELAY    = 3'h7; // Delay.

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int REF_HALF_BIT    = 21; // Reference divide-by-two enable.
  localparam int REF_DOUBLER_BIT = 20; // Reference doubler enable.
  localparam int REF_COUNT_LSB   = 15; // Five-bit reference count, 19:15.
  localparam int TIMER_LSB       = 3;  // Twelve-bit first timer and the words start here; the second timer starts at bit 7.
  localparam int FN_NSEL_BIT     = 15; // Integer-load delay.
  localparam int FN_SDCLR_BIT    = 14; // Modulator clear control.
  localparam int FN_RAMP_LSB     = 10; // Waveform type, 11:10.
  localparam int FN_PSK_BIT      = 9;  // PSK enable.
  localparam int FN_FSK_BIT      = 8;  // FSK enable.
  localparam int FN_LDP_BIT      = 7;  // Lock precision select.
  localparam int FN_POL_BIT      = 6;  // Phase detector polarity.
  localparam int FN_PD_BIT       = 5;  // Power-down.
  localparam int FN_CP3_BIT      = 4;  // Charge pump three-state.
  localparam int FN_CRST_BIT     = 3;  // Counter reset.
  localparam int TS_LESEL_BIT    = 31; // Strobe sync select.
  localparam int TS_SDM_LSB      = 26; // Modulator mode, 30:26.
  localparam int TS_DIVMODE_LSB  = 19; // Clock divider mode, 20:19.
  localparam int TS_TIMERB_LSB   = 7;  // Second timer, 18:7.
  localparam int SEL_BIT         = 23; // Deviation or step word select.
  localparam int DV_TXCLK_BIT    = 29; // Ramp clock source.
  localparam int DV_PAR_BIT      = 28; // Parabolic sweep enable.
  localparam int DV_INT_LSB      = 26; // Interrupt type, 27:26.
  localparam int DV_FSKR_BIT     = 25; // FSK ramp enable.
  localparam int DV_RAMP2_BIT    = 24; // Second ramp enable.
  localparam int DV_OFFS_LSB     = 19; // Deviation offset, 22:19.
  localparam int DL_FL_BIT       = 18; // Ramp delay fast lock.
  localparam int DL_RD_BIT       = 17; // Ramp delay.
  localparam int DL_CLK_BIT      = 16; // Delay clock select.
  localparam int DL_START_BIT    = 15; // Delayed start enable.

  // ****************************************************************
  // Mode codes, reset value and lock counts.
  // ****************************************************************
  localparam logic [4:0]  SDM_INTEGER  = 5'h0E; // Modulator disabled.
  localparam logic [31:0] REG_RESET    = 32'h0000_0000; // All fields clear.
  localparam logic [5:0]  LOCK_COUNT_A = 6'd24; // Low precision lock count.
  localparam logic [5:0]  LOCK_COUNT_B = 6'd40; // High precision lock count.
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2; // Bus transfer type.

endpackage

// ---- sscr_ref_path.sv ----
// Reference path: doubler, five-bit counter and divide-by-two stage.
`timescale 1ns/1ps
module sscr_ref_path (
  input  wire logic       hclk,        // System clock.
  input  wire logic       hresetn,     // Asynchronous reset, active low.
  input  wire logic       ref_sync,    // Synchronised reference level.
  input  wire logic       doubler_en,  // Both edges active when set.
  input  wire logic       half_en,     // Divide-by-two stage enable.
  input  wire logic [4:0] ref_count,   // Ratio minus one, 0 means 1.
  input  wire logic       hold,        // Counters held in load state.
  output logic            pfd_tick,    // One pulse per comparison edge.
  output logic            ref_edge     // One pulse per active reference edge.
);
  import sscr_pkg::*;

  logic       ref_prev;  // Reference level one cycle ago.
  logic [4:0] count;     // Reference counter.
  logic       toggle;    // Divide-by-two toggle stage.
  logic       cnt_done;  // Counter wraps this cycle.

  // Falling edge only, or both edges when doubled.
  assign ref_edge = doubler_en ? (ref_prev ^ ref_sync) : (ref_prev & ~ref_sync);
  assign cnt_done = ref_edge && (count == ref_count);

  // Edge history of the reference.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_sync;
    end
  end

  // Counter divides active edges by one to 32.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 5'h00;
    end else if (hold || cnt_done) begin
      count <= 5'h00;
    end else if (ref_edge) begin
      count <= count + 5'h01;
    end
  end

  // Toggle stage gives a half-rate, even duty comparison.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toggle   <= 1'b0;
      pfd_tick <= 1'b0;
    end else if (hold) begin
      toggle   <= 1'b0;
      pfd_tick <= 1'b0;
    end else begin
      if (cnt_done) begin
        toggle <= ~toggle;
      end
      pfd_tick <= cnt_done && (!half_en || toggle);
    end
  end
endmodule

// ---- sscr_bank.sv ----
// Top of the synthesizer sweep configuration register bank.
`timescale 1ns/1ps
module sscr_bank (
  input  wire logic        hclk,             // System clock, 250 MHz.
  input  wire logic        hresetn,          // Asynchronous reset, active low.
  input  wire logic        hsel,             // Slave select.
  input  wire logic [7:0]  haddr,            // Byte address.
  input  wire logic [1:0]  htrans,           // Transfer type.
  input  wire logic        hwrite,           // Write when high.
  input  wire logic [2:0]  hsize,            // Transfer size.
  input  wire logic [31:0] hwdata,           // Write data.
  input  wire logic        hready,           // Bus ready in.
  output logic [31:0]      hrdata,           // Read data.
  output logic             hreadyout,        // Slave ready.
  output logic             hresp,            // Always OKAY.
  input  wire logic        ser_clk,          // Serial bit clock pin.
  input  wire logic        ser_data,         // Serial data pin.
  input  wire logic        load_strobe,      // Serial load strobe pin.
  input  wire logic        ref_in,           // Reference input pin.
  input  wire logic        tx_data,          // Transmit data pin.
  input  wire logic        phase_ok,         // Phase error under 15 ns.
  input  wire logic        int_write,        // Integer/fraction word written.
  output logic             pfd_tick,         // Comparison clock pulse.
  output logic             lock_detect,      // Digital lock detect.
  output logic             pump_tristate,    // Charge pump three-state.
  output logic             counter_hold,     // Counters held in load state.
  output logic             modulator_clear,  // Sigma-delta modulator reset pulse.
  output logic             int_apply,        // Apply new integer value pulse.
  output logic             capture_pulse,    // Sweep capture on data edge.
  output logic             strobe_taken      // A serial word was loaded.
);
  import sscr_pkg::*;

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [31:0] reference_divider_ctrl; // Reference path and first timer.
  logic [31:0] function_ctrl;          // Function controls.
  logic [31:0] test_ctrl;              // Test controls.
  logic [31:0] deviation_ctrl [2];     // Two deviation words.
  logic [31:0] step_count_ctrl [2];    // Two step words.
  logic [31:0] ramp_delay_ctrl;        // Ramp delay controls.
  logic [31:0] shift_word;             // Serial shift register.

  // ****************************************************************
  // Pin synchronisers, two flops each.
  // ****************************************************************
  logic [4:0] sync_a; // First stage.
  logic [4:0] sync_b; // Second stage.
  logic [4:0] sync_c; // Edge history of the second stage.

  // All pins pass two flops before any logic reads them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_c <= 5'h00;
    end else begin
      sync_a <= {tx_data, ref_in, load_strobe, ser_data, ser_clk};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  logic ser_clk_rise; // Serial clock rising edge.
  logic strobe_rise;  // Load strobe rising edge.
  logic tx_rise;      // Transmit data rising edge.
  logic ref_edge;     // Active reference edge from the reference path.
  logic strobe_pend;  // Strobe waiting for a reference edge.
  logic load_now;     // Shifted word is transferred this cycle.

  assign ser_clk_rise = sync_b[0] & ~sync_c[0];
  assign strobe_rise  = sync_b[2] & ~sync_c[2];
  assign tx_rise      = sync_b[4] & ~sync_c[4];

  // Shift register takes bits most significant first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_word <= REG_RESET;
    end else if (ser_clk_rise) begin
      shift_word <= {shift_word[30:0], sync_b[1]};
    end
  end

  // Strobe waits for a reference edge when sync is selected; a new strobe wins over the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_pend <= 1'b0;
    end else if (strobe_rise) begin
      strobe_pend <= 1'b1;
    end else if (load_now) begin
      strobe_pend <= 1'b0;
    end
  end

  assign load_now = strobe_pend && (!test_ctrl[TS_LESEL_BIT] || ref_edge);

  // ****************************************************************
  // Bus slave: address phase capture.
  // ****************************************************************
  logic       wr_pend;  // Write data phase pending.
  logic       rd_pend;  // Read data phase pending.
  logic [7:0] addr_q;   // Captured address.
  logic       bus_wr;   // Bus write commits this cycle.
  logic [7:0] wr_addr;  // Target address of the write.
  logic [31:0] wr_data; // Word being written.

  // Capture valid transfers; the slave answers with no wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      addr_q  <= haddr;
    end
  end

  // Serial load wins the cycle; a bus write in that same cycle is dropped.
  assign bus_wr  = wr_pend && !load_now;
  assign wr_data = load_now ? shift_word : hwdata;

  // Map a serial control code to the bus address it loads.
  function automatic logic [7:0] code_addr(input logic [31:0] w);
    case (w[2:0])
      CTL_REF_DIV:  code_addr = ADDR_REF_DIV;
      CTL_FUNCTION: code_addr = ADDR_FUNCTION;
      CTL_TEST:     code_addr = ADDR_TEST;
      CTL_DEV:      code_addr = w[SEL_BIT] ? ADDR_DEV_B : ADDR_DEV_A;
      CTL_STEP:     code_addr = w[SEL_BIT] ? ADDR_STEP_B : ADDR_STEP_A;
      CTL_DELAY:    code_addr = ADDR_RAMP_DELAY;
      default:      code_addr = 8'hFF;
    endcase
  endfunction

  assign wr_addr = load_now ? code_addr(shift_word) : addr_q;

  // hreadyout stays high; a bus write that collides with a serial load is not stalled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // Register writes; registers keep contents through power-down.
  // ****************************************************************
  logic wr_en; // Any write this cycle.
  assign wr_en = load_now || bus_wr;

  // Reference, function, test and delay registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_divider_ctrl <= REG_RESET;
      function_ctrl          <= REG_RESET;
      test_ctrl              <= REG_RESET;
      ramp_delay_ctrl        <= REG_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        ADDR_REF_DIV:    reference_divider_ctrl <= wr_data;
        ADDR_FUNCTION:   function_ctrl <= wr_data;
        ADDR_TEST:       test_ctrl <= wr_data;
        ADDR_RAMP_DELAY: ramp_delay_ctrl <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Deviation and step words, each chosen by its select bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deviation_ctrl[0]  <= REG_RESET;
      deviation_ctrl[1]  <= REG_RESET;
      step_count_ctrl[0] <= REG_RESET;
      step_count_ctrl[1] <= REG_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        ADDR_DEV_A:  deviation_ctrl[0] <= wr_data;
        ADDR_DEV_B:  deviation_ctrl[1] <= wr_data;
        ADDR_STEP_A: step_count_ctrl[0] <= wr_data;
        ADDR_STEP_B: step_count_ctrl[1] <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Decoded controls.
  // ****************************************************************
  logic power_down;   // Software power-down.
  logic sdm_off;      // Modulator disabled, integer-only division.
  logic hold_now;     // Counters held this cycle.

  assign power_down = function_ctrl[FN_PD_BIT];
  assign sdm_off    = test_ctrl[TS_SDM_LSB +: 5] == SDM_INTEGER;
  assign hold_now   = power_down || function_ctrl[FN_CRST_BIT];

  sscr_ref_path u_ref (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ref_sync   (sync_b[3]),
    .doubler_en (reference_divider_ctrl[REF_DOUBLER_BIT]),
    .half_en    (reference_divider_ctrl[REF_HALF_BIT]),
    .ref_count  (reference_divider_ctrl[REF_COUNT_LSB +: 5]),
    .hold       (hold_now),
    .pfd_tick   (pfd_tick),
    .ref_edge   (ref_edge)
  );

  // Pump and counter outputs follow their control bits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_tristate <= 1'b1;
      counter_hold  <= 1'b1;
    end else begin
      pump_tristate <= power_down || function_ctrl[FN_CP3_BIT];
      counter_hold  <= hold_now;
    end
  end

  // ****************************************************************
  // Lock detect counts good comparison cycles.
  // ****************************************************************
  logic [5:0] lock_cnt;    // Consecutive good cycles.
  logic [5:0] lock_target; // Required count.
  assign lock_target = function_ctrl[FN_LDP_BIT] ? LOCK_COUNT_B : LOCK_COUNT_A;

  // A bad cycle restarts the count; power-down clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt    <= 6'h00;
      lock_detect <= 1'b0;
    end else if (power_down) begin
      lock_cnt    <= 6'h00;
      lock_detect <= 1'b0;
    end else if (pfd_tick) begin
      if (!phase_ok) begin
        lock_cnt    <= 6'h00;
        lock_detect <= 1'b0;
      end else if (lock_cnt < lock_target) begin
        lock_cnt    <= lock_cnt + 6'h01;
        lock_detect <= (lock_cnt + 6'h01) == lock_target;
      end
    end
  end

  // ****************************************************************
  // Integer/fraction load handling.
  // ****************************************************************
  logic int_wait; // Integer value held back until the fraction lands.

  // Without the delay bit the integer applies at once; with it, on the next comparison tick.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_wait        <= 1'b0;
      int_apply       <= 1'b0;
      modulator_clear <= 1'b0;
    end else begin
      modulator_clear <= int_write && !function_ctrl[FN_SDCLR_BIT];
      if (int_write && function_ctrl[FN_NSEL_BIT]) begin
        int_wait  <= 1'b1;
        int_apply <= 1'b0;
      end else if (int_wait) begin
        int_wait  <= !pfd_tick;
        int_apply <= pfd_tick;
      end else begin
        int_apply <= int_write;
      end
    end
  end

  // Capture on the data pin only when an interrupt type is chosen and the modulator is not disabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_pulse <= 1'b0;
      strobe_taken  <= 1'b0;
    end else begin
      capture_pulse <= tx_rise && !sdm_off && (deviation_ctrl[0][DV_INT_LSB +: 2] != 2'b00);
      strobe_taken  <= load_now;
    end
  end

  // ****************************************************************
  // Read data: status shows derived block state.
  // ****************************************************************
  logic [31:0] status_word; // Live status.
  assign status_word = {24'h000000, deviation_ctrl[0][DV_TXCLK_BIT], deviation_ctrl[0][DV_PAR_BIT],
                        function_ctrl[FN_POL_BIT], sdm_off, int_wait, counter_hold, pump_tristate,
                        lock_detect};

  // Read mux; unmapped addresses read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        ADDR_REF_DIV:    hrdata <= reference_divider_ctrl;
        ADDR_FUNCTION:   hrdata <= function_ctrl;
        ADDR_TEST:       hrdata <= test_ctrl;
        ADDR_DEV_A:      hrdata <= deviation_ctrl[0];
        ADDR_DEV_B:      hrdata <= deviation_ctrl[1];
        ADDR_STEP_A:     hrdata <= step_count_ctrl[0];
        ADDR_STEP_B:     hrdata <= step_count_ctrl[1];
        ADDR_RAMP_DELAY: hrdata <= ramp_delay_ctrl;
        ADDR_STATUS:     hrdata <= status_word;
        ADDR_SERIAL:     hrdata <= shift_word;
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ---- sscr_checker.sv ----
// Checker of bus, power, lock, modulator and serial load behaviour at the bank's ports.
`timescale 1ns/1ps
module sscr_checker (
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, load_strobe,
  input wire logic        phase_ok, int_write, pfd_tick, lock_detect, pump_tristate, counter_hold,
  input wire logic        modulator_clear, strobe_taken,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] hwdata
);
  import sscr_pkg::*;
  logic       fn_wr; // Data phase of a bus write to the function register.
  logic [5:0] good;  // Consecutive comparison ticks with a small phase error.
  // Marks the data phase so that hwdata can be tied to the power pins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fn_wr <= 1'b0;
    else fn_wr <= hsel && hready && htrans[1] && hwrite && haddr == ADDR_FUNCTION;
  end
  // Counts good ticks, saturating, so a lock can never rise too early.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) good <= 6'h00;
    else if (pfd_tick) good <= !phase_ok ? 6'h00 : (good == 6'h3F ? good : good + 6'h01);
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready and okay");
  power_down_a: assert property (fn_wr && hwdata[FN_PD_BIT] |-> ##[1:2] (counter_hold && pump_tristate && !lock_detect))
    else $error("power-down did not hold counters");
  pump_float_a: assert property (fn_wr && hwdata[FN_CP3_BIT] |-> ##[1:2] pump_tristate)
    else $error("pump not three-stated");
  counter_hold_a: assert property (fn_wr && hwdata[FN_CRST_BIT] |-> ##[1:2] counter_hold)
    else $error("counters not held");
  normal_run_a: assert property (fn_wr && hwdata[5:3] == 3'h0 |-> ##[1:2] !(counter_hold || pump_tristate))
    else $error("pump or counters stuck");
  lock_early_a: assert property ($rose(lock_detect) |-> good >= 6'h18) else $error("lock set too early");
  lock_drop_a: assert property (pfd_tick && !phase_ok |-> ##[1:2] !lock_detect) else $error("lock kept");
  clear_cause_a: assert property (modulator_clear |-> $past(int_write) || $past(int_write, 2))
    else $error("modulator clear without write");
  load_cause_a: assert property (strobe_taken |-> $past(load_strobe, 3) || $past(load_strobe, 4)
    || $past(load_strobe, 5) || $past(load_strobe, 6)) else $error("load without strobe");
endmodule
bind sscr_bank sscr_checker chk (.*);

// ---- sscr_host_model.sv ----
// Host controller model driving the three-wire serial load port.
`timescale 1ns/1ps
module sscr_host_model (
  input  wire logic hclk,        // Pacing clock.
  output logic      ser_clk,     // Bit clock, low between frames.
  output logic      ser_data,    // Data, inverted last bit when idle.
  output logic      load_strobe  // Load strobe after each word.
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // Shifts a word MSB first, four clocks a level, then pulses the strobe.
  task automatic send(input logic [31:0] w);
    logic [31:0] v;
    v = w;
    if (v[2:0] == 3'h4 && v[24:23] == 2'h3) v[22:21] = 2'h0;
    for (int k = 31; k >= 0; k--) begin
      ser_data <= v[k];
      repeat (4) @(posedge hclk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge hclk);
    ser_data <= ~v[0];
    load_strobe <= 1'b1;
    repeat (4) @(posedge hclk);
    load_strobe <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask
endmodule

// ---- sscr_bank_tb_top.sv ----
// Self-checking testbench of the sweep configuration register bank.
`timescale 1ns/1ps
module sscr_bank_tb_top;
  import sscr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, ser_clk, ser_data, load_strobe, ref_in, tx_data, phase_ok, int_write;
  logic        hreadyout, hresp, pfd_tick, lock_detect, pump_tristate, counter_hold;
  logic        modulator_clear, int_apply, capture_pulse, strobe_taken;
  logic [7:0]  haddr;
  logic [1:0]  htrans, s;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  int          err_total, check_count, taken, n, g, cyc;
  logic [31:0] words [9] = '{32'h0038_5FFA, 32'h0000_8243, 32'h3800_0004, 32'h1000_FFFD, 32'h1080_1235,
                             32'h007F_FFFE, 32'h00FF_FFFE, 32'h0007_FFFF, 32'hFFFF_FFF8};
  logic [2:0]  pins [4] = '{3'h6, 3'h4, 3'h2, 3'h0};
  sscr_bank dut (.*, .hready(hreadyout));
  sscr_host_model host (.*);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Reference toggles every four clocks; serial loads are counted.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) ref_in <= ~ref_in;
    taken <= taken + int'(strobe_taken);
  end
  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  // Clocks from one comparison tick to the next.
  task automatic gap(output int t);
    int c;
    c = 0; t = 0;
    do begin @(negedge hclk); c++; end while (pfd_tick !== 1'b1 && c < 400);
    do begin @(negedge hclk); t++; end while (pfd_tick !== 1'b1 && t < 400);
  endtask
  task automatic pulse_int(output logic [1:0] r);
    r = 2'h0; int_write <= 1'b1; @(posedge hclk); int_write <= 1'b0;
    repeat (5) begin @(negedge hclk); r |= {modulator_clear, int_apply}; end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    chk("watchdog", 32'h1, 32'h0);
    conclude();
  end
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0; ref_in = 0;
    tx_data = 0; phase_ok = 0; int_write = 0; cyc = 0; taken = 0; err_total = 0; check_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 8; k++) begin bus(0, 8'(4 * k), 0, q); chk("reset value", REG_RESET, q); end
    for (int k = 0; k < 9; k++) host.send(words[k]);
    for (int k = 0; k < 8; k++) begin bus(0, 8'(4 * k), 0, q); chk("serial load", words[k], q); end
    bus(0, ADDR_SERIAL, 0, q); chk("shift word", words[8], q);
    bus(0, 8'h40, 0, q); chk("unmapped read", 32'h0, q);
    chk("load count", 32'h9, 32'(taken));
    bus(0, ADDR_STATUS, 0, q); chk("status", 32'h70, q & 32'hFFFF_FFF7);
    bus(1, ADDR_TEST, 32'h4, q);
    for (int k = 0; k < 3; k++) begin
      bus(1, ADDR_REF_DIV, 32'h0001_8002 | (32'(k) << 20), q); gap(g); gap(g);
      chk("tick spacing", 32'(32 * (k / 2 + 1) / (k % 2 + 1)), 32'(g));
      @(posedge hclk);
    end
    bus(1, ADDR_REF_DIV, 32'h2, q);
    for (int k = 0; k < 2; k++) begin
      bus(1, ADDR_FUNCTION, 32'h3 | (32'(k) << FN_LDP_BIT), q); phase_ok <= 1'b0;
      repeat (20) @(posedge hclk);
      do @(negedge hclk); while (pfd_tick !== 1'b1);
      @(posedge hclk); phase_ok <= 1'b1; n = 0; g = 0;
      do begin @(negedge hclk); n += int'(pfd_tick); g++; end while (lock_detect !== 1'b1 && g < 1000);
      chk("lock ticks", k ? 32'd40 : 32'd24, 32'(n));
      @(posedge hclk);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1, ADDR_FUNCTION, 32'h3 | (k < 3 ? 32'h20 >> k : 32'h0), q); repeat (3) @(negedge hclk);
      chk("pump hold lock", 32'(pins[k]), {29'h0, pump_tristate, counter_hold, lock_detect});
      @(posedge hclk);
    end
    for (int k = 0; k < 2; k++) begin
      bus(1, ADDR_FUNCTION, 32'h3 | (32'(k) << FN_SDCLR_BIT), q); pulse_int(s);
      chk("clear apply", k ? 32'h1 : 32'h3, 32'(s));
      @(posedge hclk);
    end
    bus(1, ADDR_DEV_A, 32'h0400_0005, q); tx_data <= 1'b1; s = 2'h0;
    repeat (12) begin @(negedge hclk); s[0] |= capture_pulse; end
    chk("capture", 32'h1, 32'(s));
    conclude();
  end
endmodule
